// [logic/chz_div_pkg.sv]
// Constants shared by the channel zero clock divider files.
package chz_div_pkg;
  // Register addresses on the control port.
  localparam logic [9:0] ADDR_CYCLE_COUNTS = 10'h190;
  localparam logic [9:0] ADDR_CONTROL = 10'h191;
  localparam logic [9:0] ADDR_POWER_ROUTING = 10'h192;

  // Field positions in the cycle count register.
  localparam int LOW_CYCLES_MSB = 7;
  localparam int LOW_CYCLES_LSB = 4;
  localparam int HIGH_CYCLES_MSB = 3;
  localparam int HIGH_CYCLES_LSB = 0;

  // Field positions in the control register.
  localparam int BYPASS_BIT = 7;
  localparam int IGNORE_SYNC_BIT = 6;
  localparam int FORCE_BIT = 5;
  localparam int START_HIGH_BIT = 4;
  localparam int PHASE_MSB = 3;
  localparam int PHASE_LSB = 0;

  // Field positions in the power and routing register.
  localparam int POWER_DOWN_BIT = 2;
  localparam int DIRECT_OUT_BIT = 1;
  localparam int DCC_DISABLE_BIT = 0;
  localparam logic [7:0] POWER_ROUTING_MASK = 8'h07;

  // Reset values.
  localparam logic [7:0] CYCLE_COUNTS_RESET = 8'h77;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_ROUTING_RESET = 8'h00;

  // Distribution source select codes.
  localparam logic [1:0] SRC_EXT_CLK = 2'h0;
  localparam logic [1:0] SRC_NO_EFFECT = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;

  // Divider core states.
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_DELAY = 1'b1
  } div_state_t;
endpackage

// [logic/div_link_if.sv]
// Carrier between the register side and the divider core.
`timescale 1ns/1ps
`default_nettype none
interface div_link_if;
  logic [3:0] low_cycles;
  logic [3:0] high_cycles;
  logic bypass;
  logic ignore_sync;
  logic force_level;
  logic start_high;
  logic [3:0] phase;
  logic sync_pulse;
  logic div_out;

  modport ctrl (
    output low_cycles, high_cycles, bypass, ignore_sync, force_level, start_high, phase, sync_pulse,
    input div_out
  );
  modport core (
    input low_cycles, high_cycles, bypass, ignore_sync, force_level, start_high, phase, sync_pulse,
    output div_out
  );
endinterface
`default_nettype wire

// [logic/div_core.sv]
// High/low cycle counting divider with phase delay, force and bypass.
`timescale 1ns/1ps
`default_nettype none
module div_core (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  div_link_if.core lnk
);
  import chz_div_pkg::*;

  div_state_t state;
  logic level;
  logic [3:0] cnt;
  logic [3:0] delay_cnt;
  logic bypass_tgl;
  logic out_q;

  // A sync is honoured only while the ignore bit is clear.
  wire sync_take = lnk.sync_pulse & ~lnk.ignore_sync;
  // Forcing needs ignore set and is overridden by bypass.
  wire forced = lnk.force_level & lnk.ignore_sync & ~lnk.bypass;
  wire [3:0] limit = level ? lnk.high_cycles : lnk.low_cycles;
  wire phase_end = (level != 1'b0) ? (cnt == limit) : (cnt == limit);

  // Counter and level; a sync restarts the phase at the start level after the offset delay.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RUN;
      level <= 1'b0;
      cnt <= 4'h0;
      delay_cnt <= 4'h0;
    end else if (sync_take) begin
      level <= lnk.start_high;
      cnt <= 4'h0;
      delay_cnt <= lnk.phase;
      state <= (lnk.phase == 4'h0) ? ST_RUN : ST_DELAY;
    end else begin
      unique case (state)
        ST_DELAY: begin
          if (delay_cnt == 4'h1) begin
            state <= ST_RUN;
          end
          delay_cnt <= delay_cnt - 4'h1;
        end
        ST_RUN: begin
          if (phase_end) begin
            level <= ~level;
            cnt <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // Bypass passes the input clock through as a per-edge toggle, at half the input clock rate.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bypass_tgl <= 1'b0;
    end else begin
      bypass_tgl <= ~bypass_tgl;
    end
  end

  // Output selection is registered so the consumer sees a clean level.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_q <= 1'b0;
    end else if (lnk.bypass) begin
      out_q <= bypass_tgl;
    end else if (forced) begin
      out_q <= lnk.start_high;
    end else if (state == ST_DELAY) begin
      out_q <= lnk.start_high;
    end else begin
      out_q <= level;
    end
  end

  assign lnk.div_out = out_q;
endmodule
`default_nettype wire

// [logic/channel_zero_clock_divider.sv]
// Channel zero clock divider: registers, input synchronisers and output routing.
//
// Summary of operation
// - Low time is low field plus one.
// - High time is high field plus one.
// - Bypass powers divider down, passes input clock; here the core counter keeps running.
// - Sync obeyed unless ignore-sync bit set.
// - Force holds start level, needs ignore-sync.
// - Force has no effect while bypassed.
// - Start-level bit picks initial output level.
// - Four-bit phase offset, reset zero.
// - Power-down bit sends three outputs safe.
// - Direct with source 10b routes oscillator.
// - Direct with source 00b routes external clock.
// - Source 01b or direct clear uses divider.
// - Correction disable bit: zero enables correction.
`timescale 1ns/1ps
`default_nettype none
module channel_zero_clock_divider (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [1:0] dist_src_sel_i,
  input wire logic sync_req_i,
  input wire logic osc_clk_i,
  input wire logic ext_clk_i,
  output logic group_output_a_o,
  output logic group_output_b_o,
  output logic group_output_c_o,
  output logic duty_cycle_correction_en_o
);
  import chz_div_pkg::*;

  // Register storage.
  logic [7:0] cycle_counts;
  logic [7:0] control;
  logic [2:0] power_routing;

  // Synchronisers for pins outside the clock domain.
  logic sync_meta;
  logic sync_sync;
  logic sync_prev;
  logic osc_meta;
  logic osc_sync;
  logic ext_meta;
  logic ext_sync;

  div_link_if lnk ();

  // Address decode for the control port.
  wire sel_counts = (reg_addr_i == ADDR_CYCLE_COUNTS);
  wire sel_control = (reg_addr_i == ADDR_CONTROL);
  wire sel_power = (reg_addr_i == ADDR_POWER_ROUTING);
  wire wr_counts = reg_wr_i & sel_counts;
  wire wr_control = reg_wr_i & sel_control;
  wire wr_power = reg_wr_i & sel_power;

  // Read data; reserved bits and unmapped addresses read as zero.
  wire [7:0] read_mux = sel_counts ? cycle_counts :
                        sel_control ? control :
                        sel_power ? {5'h00, power_routing} : 8'h00;

  // Cycle count register, reset to eight low and eight high cycles.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycle_counts <= CYCLE_COUNTS_RESET;
    end else if (wr_counts) begin
      cycle_counts <= reg_wdata_i;
    end
  end

  // Control register: bypass, ignore sync, force, start level and phase offset.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      control <= CONTROL_RESET;
    end else if (wr_control) begin
      control <= reg_wdata_i;
    end
  end

  // Power and routing register; only the three low bits are implemented.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_routing <= POWER_ROUTING_RESET[2:0];
    end else if (wr_power) begin
      power_routing <= reg_wdata_i[2:0] & POWER_ROUTING_MASK[2:0];
    end
  end

  // Registered read port; data appears one clock after the read strobe.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_mux;
    end
  end

  // Two-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      sync_meta <= sync_req_i;
      sync_sync <= sync_meta;
      osc_meta <= osc_clk_i;
      osc_sync <= osc_meta;
      ext_meta <= ext_clk_i;
      ext_sync <= ext_meta;
    end
  end

  // Edge history on the settled sync level, so one request is one restart.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_sync;
    end
  end

  // Configuration to the divider core.
  assign lnk.low_cycles = cycle_counts[LOW_CYCLES_MSB:LOW_CYCLES_LSB];
  assign lnk.high_cycles = cycle_counts[HIGH_CYCLES_MSB:HIGH_CYCLES_LSB];
  assign lnk.bypass = control[BYPASS_BIT];
  assign lnk.ignore_sync = control[IGNORE_SYNC_BIT];
  assign lnk.force_level = control[FORCE_BIT];
  assign lnk.start_high = control[START_HIGH_BIT];
  assign lnk.phase = control[PHASE_MSB:PHASE_LSB];
  assign lnk.sync_pulse = sync_sync & ~sync_prev;

  div_core u_core (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .lnk(lnk)
  );

  // Output routing: direct paths only for codes 00b and 10b; 01b keeps the divider.
  wire pwr_down = power_routing[POWER_DOWN_BIT];
  wire direct = power_routing[DIRECT_OUT_BIT];
  wire route_osc = direct & (dist_src_sel_i == SRC_OSC);
  wire route_ext = direct & (dist_src_sel_i == SRC_EXT_CLK);
  wire group_src = route_osc ? osc_sync :
                   route_ext ? ext_sync : lnk.div_out;
  // Safe power-down parks all three outputs low.
  wire next_group = pwr_down ? 1'b0 : group_src;

  // The three outputs share one source but each has its own flop, as each feeds its own driver.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      group_output_a_o <= 1'b0;
      group_output_b_o <= 1'b0;
      group_output_c_o <= 1'b0;
    end else begin
      group_output_a_o <= next_group;
      group_output_b_o <= next_group;
      group_output_c_o <= next_group;
    end
  end

  // Correction enable is the inverse of the disable bit; the correction itself is analog.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duty_cycle_correction_en_o <= 1'b1;
    end else begin
      duty_cycle_correction_en_o <= ~power_routing[DCC_DISABLE_BIT];
    end
  end
endmodule
`default_nettype wire

// [verif/chz_div_checker.sv]
// Port-level assertion checker for the channel zero clock divider.
`timescale 1ns/1ps
`default_nettype none
module chz_div_checker (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] dist_src_sel_i,
  input wire logic sync_req_i,
  input wire logic osc_clk_i,
  input wire logic group_output_a_o,
  input wire logic group_output_b_o,
  input wire logic group_output_c_o,
  input wire logic duty_cycle_correction_en_o
);
  import chz_div_pkg::*;
  logic [7:0] cnt, ctl, pr;
  logic [5:0] quiet, run;
  logic out_q, sync_q;
  logic [1:0] sel_q;
  wire out = group_output_a_o;
  wire direct = pr[1] && !dist_src_sel_i[0];
  wire div_mode = !ctl[7] && !(ctl[5] && ctl[6]) && !pr[2] && !direct && quiet > 6'h28;
  // Shadow registers; a write, sync edge or source change restarts the quiet spell, so half periods in flux are skipped.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= CYCLE_COUNTS_RESET;
      ctl <= CONTROL_RESET;
      pr <= POWER_ROUTING_RESET;
      {quiet, run, out_q, sync_q, sel_q} <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_CYCLE_COUNTS) cnt <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_CONTROL) ctl <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_POWER_ROUTING) pr <= reg_wdata_i & POWER_ROUTING_MASK;
      quiet <= (reg_wr_i || sync_req_i != sync_q || dist_src_sel_i != sel_q) ? 6'h00 : quiet + {5'h00, quiet != 6'h3F};
      run <= (out != out_q) ? 6'h01 : run + {5'h00, run != 6'h3F};
      {out_q, sync_q, sel_q} <= {out, sync_req_i, dist_src_sel_i};
    end
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  same_outputs_a: assert property (out == group_output_b_o && out == group_output_c_o)
    else $error("group outputs differ");
  high_time_a: assert property (div_mode && out_q && !out |-> run == {2'h0, cnt[3:0]} + 6'h01)
    else $error("high half length wrong");
  low_time_a: assert property (div_mode && !out_q && out |-> run == {2'h0, cnt[7:4]} + 6'h01)
    else $error("low half length wrong");
  bypass_toggle_a: assert property (ctl[7] && !pr[2] && !direct && quiet > 6'h04 |-> out != out_q)
    else $error("bypass does not pass the clock");
  force_level_a: assert property (!ctl[7] && ctl[6] && ctl[5] && !pr[2] && !direct && quiet > 6'h04
    |-> out == ctl[4])
    else $error("forced level wrong");
  power_down_a: assert property (pr[2] && $past(pr[2]) |-> !out)
    else $error("outputs active while powered down");
  direct_osc_a: assert property (direct && dist_src_sel_i == SRC_OSC && !pr[2] && quiet > 6'h04
    |-> out == $past(osc_clk_i, 3))
    else $error("oscillator not routed");
  dcc_level_a: assert property ($stable(pr[0]) |-> duty_cycle_correction_en_o == !pr[0])
    else $error("correction enable wrong");
  cover property (ctl[4] && !ctl[6] && $rose(sync_req_i));
  cover property (direct && dist_src_sel_i == SRC_EXT_CLK && quiet > 6'h10);
  cover property (ctl[7] && ctl[5] && quiet > 6'h10);
endmodule
bind channel_zero_clock_divider chz_div_checker chz_div_checker_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .dist_src_sel_i(dist_src_sel_i),
  .sync_req_i(sync_req_i), .osc_clk_i(osc_clk_i), .group_output_a_o(group_output_a_o),
  .group_output_b_o(group_output_b_o), .group_output_c_o(group_output_c_o),
  .duty_cycle_correction_en_o(duty_cycle_correction_en_o));
`default_nettype wire

// [verif/group_drivers_model.sv]
// Behavioural model of the three output drivers of the group.
`timescale 1ns/1ps
`default_nettype none
module group_drivers_model (
  input wire logic drv_a_i,
  input wire logic drv_b_i,
  input wire logic drv_c_i,
  output logic agree_o
);
  // The drivers share one source (divider, oscillator or external clock), so any skew between them means a broken fan-out.
  assign agree_o = drv_a_i === drv_b_i && drv_b_i === drv_c_i;
endmodule
`default_nettype wire

// [verif/channel_zero_clock_divider_tb_top.sv]
// Self-checking bench for the channel zero clock divider.
`timescale 1ns/1ps
`default_nettype none
module channel_zero_clock_divider_tb_top;
  import chz_div_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] sel = 2'h0;
  logic sync = 1'b0;
  logic osc = 1'b0;
  logic ext = 1'b0;
  logic [1:0] k3 = 2'h0;
  logic [7:0] rdata;
  logic out_a, out_b, out_c, dcc, agree;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  // Clock; the oscillator toggles every cycle and the external clock every third, so routes tell apart.
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    osc <= ~osc;
    k3 <= (k3 == 2'h2) ? 2'h0 : k3 + 2'h1;
    if (k3 == 2'h2) ext <= ~ext;
    if (cycles > 20000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end
  channel_zero_clock_divider channel_zero_clock_divider_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .dist_src_sel_i(sel),
    .sync_req_i(sync), .osc_clk_i(osc), .ext_clk_i(ext), .group_output_a_o(out_a), .group_output_b_o(out_b),
    .group_output_c_o(out_c), .duty_cycle_correction_en_o(dcc));
  group_drivers_model group_drivers_model_i (.drv_a_i(out_a), .drv_b_i(out_b), .drv_c_i(out_c), .agree_o(agree));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    {addr, rd} <= {a, 1'b1};
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    check(rdata, exp);
  endtask
  // Bounded wait for the output to reach a level.
  task automatic wait_lvl(input logic lvl);
    for (int i = 0; i < 60 && out_a !== lvl; i++) @(negedge mclk_i);
  endtask
  // Length in cycles of the next whole stretch at the given level.
  task automatic stretch(input logic lvl, output int len);
    len = 0;
    wait_lvl(!lvl);
    wait_lvl(lvl);
    while (out_a === lvl && len < 60) begin
      len++;
      @(negedge mclk_i);
    end
  endtask
  // Output transitions over 24 cycles, after settling.
  task automatic edges(output int cnt);
    logic prev;
    cnt = 0;
    repeat (8) @(negedge mclk_i);
    prev = out_a;
    repeat (24) begin
      @(negedge mclk_i);
      cnt += (out_a !== prev);
      prev = out_a;
    end
  endtask
  task automatic t_reset();
    rreg(ADDR_CYCLE_COUNTS, 8'h77);
    rreg(ADDR_CONTROL, 8'h00);
    rreg(ADDR_POWER_ROUTING, 8'h00);
    rreg(10'h1FF, 8'h00);
    check({7'h00, dcc}, 8'h01);
    stretch(1'b1, n);
    check(8'(n), 8'h08);
    stretch(1'b0, n);
    check(8'(n), 8'h08);
  endtask
  task automatic t_counts();
    logic [7:0] tbl [3] = '{8'h2F, 8'h0F, 8'hF2};
    foreach (tbl[i]) begin
      wreg(ADDR_CYCLE_COUNTS, tbl[i]);
      repeat (40) @(negedge mclk_i);
      stretch(1'b1, n);
      check(8'(n), {4'h0, tbl[i][3:0]} + 8'h01);
      stretch(1'b0, n);
      check(8'(n), {4'h0, tbl[i][7:4]} + 8'h01);
    end
  endtask
  // Sync mid low half: start high plus three cycles of phase, unless ignored.
  task automatic t_sync(input logic [7:0] ctl, input int exp);
    wreg(ADDR_CONTROL, ctl);
    repeat (40) @(negedge mclk_i);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    @(posedge mclk_i);
    sync <= 1'b1;
    stretch(1'b1, n);
    check(8'(n), 8'(exp));
    @(posedge mclk_i);
    sync <= 1'b0;
  endtask
  task automatic t_force();
    wreg(ADDR_CONTROL, 8'h70);
    edges(n);
    check(8'(n), 8'h00);
    check({7'h00, out_a}, 8'h01);
    wreg(ADDR_CONTROL, 8'h20);
    edges(n);
    check({7'h00, n > 0}, 8'h01);
    wreg(ADDR_CONTROL, 8'hE0);
    edges(n);
    check(8'(n), 8'h18);
    wreg(ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_route();
    wreg(ADDR_POWER_ROUTING, 8'h02);
    sel <= SRC_OSC;
    edges(n);
    check(8'(n), 8'h18);
    sel <= SRC_EXT_CLK;
    edges(n);
    check(8'(n), 8'h08);
    sel <= SRC_NO_EFFECT;
    edges(n);
    check({7'h00, n < 5}, 8'h01);
    check({7'h00, agree}, 8'h01);
    wreg(ADDR_POWER_ROUTING, 8'h06);
    sel <= SRC_OSC;
    edges(n);
    check({out_a, 7'(n)}, 8'h00);
    wreg(ADDR_POWER_ROUTING, 8'hFF);
    rreg(ADDR_POWER_ROUTING, 8'h07);
    check({7'h00, dcc}, 8'h00);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_counts();
    t_sync(8'h13, 6);
    t_sync(8'h53, 3);
    t_force();
    t_route();
    wrap_up();
  end
endmodule
`default_nettype wire
